// ---- rtl/queue_mgr_pkg.sv ----
// constants shared by the hardware queue manager and its read buffer
package queue_mgr_pkg;
    // queue population and widths
    localparam int NUM_QUEUES    = 64;
    localparam int LOWER_QUEUES  = 32;   // queues with the full flag set
    localparam int QID_W         = 6;
    localparam int WORD_W        = 32;
    localparam int PTR_W         = 7;    // word pointer inside a queue
    localparam int FILL_W        = 8;    // entries held, up to 128
    localparam int WM_W          = 7;    // watermark level, up to 64
    localparam int MEM_AW        = QID_W + PTR_W;

    // queue size code: words = base << code (16, 32, 64, 128)
    localparam int          QUEUE_BASE_WORDS = 16;
    localparam logic [1:0]  SIZE_CODE_RESET  = 2'h0;

    // entry size code: words = 1 << code (1, 2, 4); code 3 is illegal
    localparam logic [1:0]  ENTRY_CODE_RESET = 2'h0;
    localparam logic [1:0]  ENTRY_CODE_BAD   = 2'h3;

    // watermark code: 0 -> 0 entries, n -> 1 << (n-1) (0,1,2,4..64)
    localparam logic [2:0]  WM_CODE_RESET    = 3'h0;

    // status vector bit positions
    localparam int STAT_W        = 6;
    localparam int STAT_EMPTY    = 0;
    localparam int STAT_NEMPTY   = 1;
    localparam int STAT_NFULL    = 2;
    localparam int STAT_FULL     = 3;
    localparam int STAT_UNDER    = 4;
    localparam int STAT_OVER     = 5;

    // interrupt source select
    localparam logic        INT_SEL_NEMPTY   = 1'b0;
    localparam logic        INT_SEL_FULL     = 1'b1;

    // read data buffer
    localparam int RD_FIFO_DEPTH = 4;
    localparam int RD_FIFO_W     = WORD_W + 2;   // {source, underflow, word}
endpackage

// ---- rtl/queue_rd_fifo.sv ----
// small synchronous fifo carrying read words out of the queue manager
`timescale 1ns/100ps
module queue_rd_fifo #(
    parameter int WIDTH = 34,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             clk_sys_i,
    input  wire logic             rst_i,
    // filling side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // draining side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];   // entry storage
    logic [AW-1:0]    wr_ptr;          // next slot to fill
    logic [AW-1:0]    rd_ptr;          // oldest slot
    logic [AW:0]      count;           // words held
    logic             push;
    logic             pop;

    // honest flags straight from the count
    assign in_ready_o  = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;
    assign out_data_o  = store[rd_ptr];

    // storage write, no reset needed on data
    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            store[wr_ptr] <= in_data_i;
        end
    end

    // pointers wrap at depth, which need not be a power of two
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
        end
    end

    // occupancy, simultaneous push and pop cancel
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            count <= '0;
        end else if (push && !pop) begin
            count <= count + 1'b1;
        end else if (pop && !push) begin
            count <= count - 1'b1;
        end
    end
endmodule // queue_rd_fifo

// ---- rtl/hw_queue_mgr.sv ----
// hardware queue manager: 64 queues, fill status, watermarks, interrupts
// Function
// - queues 0-31 keep six status flags
// - queues 32-63 keep only nearly empty, full
// - overflow recorded only for queues 0-31
// - entry transfers configured entry size in words
// - sticky mode: clear needs write-one, condition gone
// - watermarks 0,1,2,4,8,16,32,64 entries only
// - queues 32-63 ignore nearly-full threshold
// - engine and host accesses both update status
// - underflow recorded only for queues 0-31
// - queue sizes 16, 32, 64, 128 words
// - entry sizes 1, 2 or 4 words
`timescale 1ns/100ps
module hw_queue_mgr
    import queue_mgr_pkg::*;
(
    // clock and reset
    input  wire logic              clk_sys_i,
    input  wire logic              rst_i,
    // queue configuration
    input  wire logic              cfg_we_i,
    input  wire logic [QID_W-1:0]  cfg_qid_i,
    input  wire logic [1:0]        cfg_size_i,
    input  wire logic [1:0]        cfg_entry_i,
    input  wire logic [2:0]        cfg_ne_i,
    input  wire logic [2:0]        cfg_nf_i,
    input  wire logic              cfg_int_sel_i,
    output logic                   cfg_err_o,
    // interrupt mode and clearing
    input  wire logic              sticky_en_i,
    input  wire logic              int_clr_we_i,
    input  wire logic [NUM_QUEUES-1:0] int_clr_i,
    output logic [NUM_QUEUES-1:0]  int_stat_o,
    // processing engine word access
    input  wire logic              eng_valid_i,
    output logic                   eng_ready_o,
    input  wire logic              eng_read_i,
    input  wire logic [QID_W-1:0]  eng_qid_i,
    input  wire logic [WORD_W-1:0] eng_data_i,
    // host word access
    input  wire logic              host_valid_i,
    output logic                   host_ready_o,
    input  wire logic              host_read_i,
    input  wire logic [QID_W-1:0]  host_qid_i,
    input  wire logic [WORD_W-1:0] host_data_i,
    // read data stream
    output logic                   rd_valid_o,
    input  wire logic              rd_ready_i,
    output logic [WORD_W-1:0]      rd_data_o,
    output logic                   rd_src_eng_o,
    output logic                   rd_underflow_o,
    // status query
    input  wire logic              stat_rd_i,
    input  wire logic [QID_W-1:0]  stat_qid_i,
    output logic [STAT_W-1:0]      stat_o
);

    // entry size code to log2 of words per entry
    function automatic logic [1:0] entry_log(input logic [1:0] code);
        return (code == ENTRY_CODE_BAD) ? 2'h0 : code;
    endfunction

    // queue size code to word mask for pointer wrap
    function automatic logic [PTR_W-1:0] size_mask(input logic [1:0] code);
        return PTR_W'((QUEUE_BASE_WORDS << code) - 1);
    endfunction

    // capacity in entries from size and entry codes
    function automatic logic [FILL_W-1:0] cap_entries(
        input logic [1:0] size_code,
        input logic [1:0] entry_code
    );
        logic [FILL_W-1:0] words;
        words = FILL_W'(QUEUE_BASE_WORDS << size_code);
        return words >> entry_log(entry_code);
    endfunction

    // watermark code to level in entries
    function automatic logic [WM_W-1:0] wm_level(input logic [2:0] code);
        return (code == 3'h0) ? '0 : WM_W'(1 << (code - 3'h1));
    endfunction

    // per queue configuration
    logic [1:0]          q_size    [NUM_QUEUES];  // size code
    logic [1:0]          q_entry   [NUM_QUEUES];  // entry size code
    logic [WM_W-1:0]     q_ne_lvl  [NUM_QUEUES];  // nearly empty level
    logic [WM_W-1:0]     q_nf_lvl  [NUM_QUEUES];  // nearly full level
    logic [NUM_QUEUES-1:0] q_int_sel;             // interrupt source

    // per queue pointers and occupancy
    logic [PTR_W-1:0]    wr_ptr    [NUM_QUEUES];  // next word to write
    logic [PTR_W-1:0]    rd_ptr    [NUM_QUEUES];  // next word to read
    logic [1:0]          wr_phase  [NUM_QUEUES];  // word within entry
    logic [1:0]          rd_phase  [NUM_QUEUES];
    logic [FILL_W-1:0]   fill      [NUM_QUEUES];  // whole entries held

    // queue word storage, one region of 128 words per queue
    logic [WORD_W-1:0]   mem [2**MEM_AW];

    // sticky error flags and interrupt tracking
    logic [NUM_QUEUES-1:0] under_flag;            // underflow_flag per queue
    logic [NUM_QUEUES-1:0] over_flag;             // overflow_flag per queue
    logic [NUM_QUEUES-1:0] cond_q;                // condition last cycle
    logic [NUM_QUEUES-1:0] int_reg;               // interrupt register

    // live flag vectors
    logic [NUM_QUEUES-1:0] empty_v;
    logic [NUM_QUEUES-1:0] nearly_empty_flag;
    logic [NUM_QUEUES-1:0] nearly_full_flag;
    logic [NUM_QUEUES-1:0] full_v;
    logic [NUM_QUEUES-1:0] int_cond;

    // arbitrated access
    logic                  eng_go;
    logic                  host_go;
    logic                  acc_go;
    logic                  acc_read;
    logic                  acc_src_eng;
    logic [QID_W-1:0]      acc_qid;
    logic [WORD_W-1:0]     acc_data;
    logic                  acc_full;
    logic                  acc_empty;
    logic                  wr_ok;
    logic                  rd_ok;
    logic                  wr_last;
    logic                  rd_last;
    logic [WORD_W-1:0]     rd_word;
    logic                  fifo_in_ready;
    logic [RD_FIFO_W-1:0]  fifo_out;

    // flags from occupancy against capacity and thresholds
    always_comb begin
        logic [FILL_W-1:0] cap;
        cap = '0;
        for (int q = 0; q < NUM_QUEUES; q++) begin
            cap = cap_entries(q_size[q], q_entry[q]);
            // ne and full exist for all queues
            nearly_empty_flag[q] = fill[q] <= {1'b0, q_ne_lvl[q]};
            full_v[q]            = fill[q] == cap;
            if (q < LOWER_QUEUES) begin
                empty_v[q]          = fill[q] == '0;
                nearly_full_flag[q] =
                    (cap - fill[q]) <= {1'b0, q_nf_lvl[q]};
            end else begin
                // upper queues have no empty or nearly full flag
                empty_v[q]          = 1'b0;
                nearly_full_flag[q] = 1'b0;
            end
            int_cond[q] = (q_int_sel[q] == INT_SEL_FULL) ?
                          full_v[q] : nearly_empty_flag[q];
        end
    end

    // engine first; a read waits while the read buffer is full
    assign eng_go       = eng_valid_i & (~eng_read_i | fifo_in_ready);
    assign host_go      = ~eng_valid_i & host_valid_i &
                          (~host_read_i | fifo_in_ready);
    assign eng_ready_o  = eng_go;
    assign host_ready_o = host_go;

    // both requesters drive the same queue state
    assign acc_go      = eng_go | host_go;
    assign acc_src_eng = eng_go;
    assign acc_read    = eng_go ? eng_read_i : host_read_i;
    assign acc_qid     = eng_go ? eng_qid_i  : host_qid_i;
    assign acc_data    = eng_go ? eng_data_i : host_data_i;

    // per word decisions against the addressed queue
    assign acc_full  = full_v[acc_qid];
    assign acc_empty = fill[acc_qid] == '0;
    assign wr_ok     = acc_go & ~acc_read & ~acc_full;
    assign rd_ok     = acc_go & acc_read & ~acc_empty;
    // entry completes after 1 << entry_log words
    assign wr_last   = wr_phase[acc_qid] ==
                       2'((3'h1 << entry_log(q_entry[acc_qid])) - 3'h1);
    assign rd_last   = rd_phase[acc_qid] ==
                       2'((3'h1 << entry_log(q_entry[acc_qid])) - 3'h1);
    assign rd_word   = rd_ok ? mem[{acc_qid, rd_ptr[acc_qid]}] : '0;
    assign cfg_err_o = cfg_we_i & (cfg_entry_i == ENTRY_CODE_BAD);

    // queue word storage write
    always_ff @(posedge clk_sys_i) begin
        if (wr_ok) begin
            mem[{acc_qid, wr_ptr[acc_qid]}] <= acc_data;
        end
    end

    // configuration; a bad entry code is refused outright
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            for (int q = 0; q < NUM_QUEUES; q++) begin
                q_size[q]   <= SIZE_CODE_RESET;
                q_entry[q]  <= ENTRY_CODE_RESET;
                q_ne_lvl[q] <= wm_level(WM_CODE_RESET);
                q_nf_lvl[q] <= wm_level(WM_CODE_RESET);
            end
            q_int_sel <= '0;
        end else if (cfg_we_i && !cfg_err_o) begin
            q_size[cfg_qid_i]    <= cfg_size_i;
            q_entry[cfg_qid_i]   <= cfg_entry_i;
            q_ne_lvl[cfg_qid_i]  <= wm_level(cfg_ne_i);
            // upper queues drop the nearly full level
            q_nf_lvl[cfg_qid_i]  <= (cfg_qid_i < QID_W'(LOWER_QUEUES)) ?
                                    wm_level(cfg_nf_i) : '0;
            q_int_sel[cfg_qid_i] <= cfg_int_sel_i;
        end
    end

    // pointers, phases and fill; configuring a queue empties it, so
    // thresholds never meet stale contents
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            for (int q = 0; q < NUM_QUEUES; q++) begin
                wr_ptr[q]   <= '0;
                rd_ptr[q]   <= '0;
                wr_phase[q] <= '0;
                rd_phase[q] <= '0;
                fill[q]     <= '0;
            end
        end else if (cfg_we_i && !cfg_err_o) begin
            wr_ptr[cfg_qid_i]   <= '0;
            rd_ptr[cfg_qid_i]   <= '0;
            wr_phase[cfg_qid_i] <= '0;
            rd_phase[cfg_qid_i] <= '0;
            fill[cfg_qid_i]     <= '0;
        end else if (wr_ok) begin
            // word goes in; entry counts only when its last word lands
            wr_ptr[acc_qid] <= (wr_ptr[acc_qid] + 1'b1) &
                               size_mask(q_size[acc_qid]);
            if (wr_last) begin
                wr_phase[acc_qid] <= '0;
                fill[acc_qid]     <= fill[acc_qid] + 1'b1;
            end else begin
                wr_phase[acc_qid] <= wr_phase[acc_qid] + 1'b1;
            end
        end else if (rd_ok) begin
            rd_ptr[acc_qid] <= (rd_ptr[acc_qid] + 1'b1) &
                               size_mask(q_size[acc_qid]);
            if (rd_last) begin
                rd_phase[acc_qid] <= '0;
                fill[acc_qid]     <= fill[acc_qid] - 1'b1;
            end else begin
                rd_phase[acc_qid] <= rd_phase[acc_qid] + 1'b1;
            end
        end
    end

    // overflow and underflow latch on lower queues; a status read
    // clears them, but a fresh event in that cycle wins
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            over_flag  <= '0;
            under_flag <= '0;
        end else begin
            for (int q = 0; q < NUM_QUEUES; q++) begin
                if (stat_rd_i && stat_qid_i == QID_W'(q)) begin
                    over_flag[q]  <= 1'b0;
                    under_flag[q] <= 1'b0;
                end
                if (q < LOWER_QUEUES && acc_go && acc_qid == QID_W'(q)) begin
                    if (!acc_read && acc_full) begin
                        over_flag[q] <= 1'b1;
                    end
                    if (acc_read && acc_empty) begin
                        under_flag[q] <= 1'b1;
                    end
                end
            end
        end
    end

    // condition history for edge detection in normal mode; reset queues
    // sit nearly empty, so history starts high to avoid a false edge
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            cond_q <= '1;
        end else begin
            cond_q <= int_cond;
        end
    end

    // interrupt register; mode must be settled before queues run
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            int_reg <= '0;
        end else begin
            for (int q = 0; q < NUM_QUEUES; q++) begin
                if (sticky_en_i) begin
                    // sticky: bit holds while condition holds
                    if (int_cond[q]) begin
                        int_reg[q] <= 1'b1;
                    end else if (int_clr_we_i && int_clr_i[q]) begin
                        int_reg[q] <= 1'b0;
                    end
                end else begin
                    // normal: set on rising condition, set beats clear
                    if (int_cond[q] && !cond_q[q]) begin
                        int_reg[q] <= 1'b1;
                    end else if (int_clr_we_i && int_clr_i[q]) begin
                        int_reg[q] <= 1'b0;
                    end
                end
            end
        end
    end
    assign int_stat_o = int_reg;

    // status snapshot; can move between reads as engines run
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            stat_o <= '0;
        end else begin
            stat_o[STAT_EMPTY]  <= empty_v[stat_qid_i];
            stat_o[STAT_NEMPTY] <= nearly_empty_flag[stat_qid_i];
            stat_o[STAT_NFULL]  <= nearly_full_flag[stat_qid_i];
            stat_o[STAT_FULL]   <= full_v[stat_qid_i];
            stat_o[STAT_UNDER]  <= under_flag[stat_qid_i];
            stat_o[STAT_OVER]   <= over_flag[stat_qid_i];
        end
    end

    // read words, including refused reads as zero, leave via buffer
    queue_rd_fifo #(
        .WIDTH (RD_FIFO_W),
        .DEPTH (RD_FIFO_DEPTH)
    ) u_rd_fifo (
        .clk_sys_i   (clk_sys_i),
        .rst_i       (rst_i),
        .in_valid_i  (acc_go & acc_read),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   ({acc_src_eng, ~rd_ok, rd_word}),
        .out_valid_o (rd_valid_o),
        .out_ready_i (rd_ready_i),
        .out_data_o  (fifo_out)
    );

    // unpack buffered read
    assign rd_data_o      = fifo_out[WORD_W-1:0];
    assign rd_underflow_o = fifo_out[WORD_W];
    assign rd_src_eng_o   = fifo_out[WORD_W+1];
endmodule // hw_queue_mgr

// ---- sim/hw_queue_mgr_monitor.sv ----
// port checker for the hardware queue manager
`timescale 1ns/100ps
module hw_queue_mgr_monitor
    import queue_mgr_pkg::*;
(
    // clock and reset
    input wire logic                  clk_sys_i,
    input wire logic                  rst_i,
    // configuration
    input wire logic                  cfg_we_i,
    input wire logic [QID_W-1:0]      cfg_qid_i,
    input wire logic [1:0]            cfg_entry_i,
    input wire logic                  cfg_err_o,
    // interrupts
    input wire logic                  int_clr_we_i,
    input wire logic [NUM_QUEUES-1:0] int_clr_i,
    input wire logic [NUM_QUEUES-1:0] int_stat_o,
    // word access
    input wire logic                  eng_valid_i,
    input wire logic                  eng_ready_o,
    input wire logic                  eng_read_i,
    input wire logic                  host_valid_i,
    input wire logic                  host_ready_o,
    // read stream
    input wire logic                  rd_valid_o,
    input wire logic                  rd_ready_i,
    input wire logic [WORD_W-1:0]     rd_data_o,
    input wire logic                  rd_src_eng_o,
    input wire logic                  rd_underflow_o,
    // status
    input wire logic [QID_W-1:0]      stat_qid_i,
    input wire logic [STAT_W-1:0]     stat_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // set bits not hit by a write-one; these must survive the edge
    logic [NUM_QUEUES-1:0] keep_m;
    assign keep_m = int_stat_o & ~(int_clr_we_i ? int_clr_i : '0);

    cfg_refuse_a: assert property (
        cfg_err_o == (cfg_we_i && cfg_entry_i == ENTRY_CODE_BAD))
        else $error("config error flag mismatch");
    host_yield_a: assert property (eng_valid_i |-> !host_ready_o)
        else $error("host served while engine requests");
    upper_flags_a: assert property (
        stat_qid_i[QID_W-1] |=> (stat_o & 6'h35) == 6'h00)
        else $error("upper queue shows absent flag");
    cfg_empty_a: assert property (
        (cfg_we_i && !cfg_err_o && !eng_valid_i && !host_valid_i) ##1
        (stat_qid_i == $past(cfg_qid_i) && !cfg_we_i && !eng_valid_i
        && !host_valid_i) |=> stat_o[STAT_NEMPTY]
        && (stat_o[STAT_EMPTY] == ($past(stat_qid_i) < LOWER_QUEUES)))
        else $error("configured queue not empty");
    uflow_zero_a: assert property (
        rd_valid_o && rd_underflow_o |-> rd_data_o == 32'h0)
        else $error("underflow word not zero");
    rd_hold_a: assert property (
        rd_valid_o && !rd_ready_i |=> rd_valid_o && $stable(rd_data_o)
        && $stable(rd_src_eng_o))
        else $error("read word changed while stalled");
    rd_answer_a: assert property (
        eng_valid_i && eng_ready_o && eng_read_i && !rd_valid_o
        && !cfg_we_i |=> rd_valid_o && rd_src_eng_o)
        else $error("engine read not answered next cycle");
    int_keep_a: assert property (
        !cfg_we_i |=> (int_stat_o & $past(keep_m)) == $past(keep_m))
        else $error("interrupt bit fell without write");
endmodule // hw_queue_mgr_monitor

// ---- sim/rd_sink_model.sv ----
// consumer of the read stream, with optional random stalls
`timescale 1ns/100ps
module rd_sink_model
    import queue_mgr_pkg::*;
(
    // clock and reset
    input wire logic              clk_sys_i,
    input wire logic              rst_i,
    // stall control from the bench
    input wire logic              stall_en_i,
    // read stream
    input wire logic              rd_valid_i,
    input wire logic [WORD_W-1:0] rd_data_i,
    input wire logic              rd_src_eng_i,
    input wire logic              rd_underflow_i,
    output logic                  rd_ready_o
);
    logic [RD_FIFO_W-1:0] got_q[$];  // words taken, oldest first
    // take on valid and ready, then pick next ready level
    initial begin
        rd_ready_o = 1'b0;
        forever begin
            @(posedge clk_sys_i);
            if (rd_valid_i && rd_ready_o)
                got_q.push_back({rd_src_eng_i, rd_underflow_i, rd_data_i});
            rd_ready_o <= !rst_i && (!stall_en_i || $urandom % 3 == 0);
        end
    end
endmodule // rd_sink_model

// ---- sim/hw_queue_status_watermarks_tb.sv ----
// self-checking bench for the hardware queue manager
`timescale 1ns/100ps
module hw_queue_status_watermarks_tb
    import queue_mgr_pkg::*;
;
    logic clk_sys_i, rst_i, cfg_we_i, cfg_int_sel_i, cfg_err_o, stall_en;
    logic [QID_W-1:0] cfg_qid_i, eng_qid_i, host_qid_i, stat_qid_i;
    logic [1:0] cfg_size_i, cfg_entry_i;
    logic [2:0] cfg_ne_i, cfg_nf_i;
    logic sticky_en_i, int_clr_we_i, stat_rd_i;
    logic [NUM_QUEUES-1:0] int_clr_i, int_stat_o;
    logic eng_valid_i, eng_ready_o, eng_read_i;
    logic host_valid_i, host_ready_o, host_read_i;
    logic [WORD_W-1:0] eng_data_i, host_data_i, rd_data_o;
    logic rd_valid_o, rd_ready_i, rd_src_eng_o, rd_underflow_o;
    logic [STAT_W-1:0] stat_o, st;
    logic [WORD_W-1:0] sb[$];  // words written, in queue order
    int error_cnt, tests_run;

    hw_queue_mgr uut (.*);
    rd_sink_model sink (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .stall_en_i(stall_en), .rd_valid_i(rd_valid_o),
        .rd_data_i(rd_data_o), .rd_src_eng_i(rd_src_eng_o),
        .rd_underflow_i(rd_underflow_o), .rd_ready_o(rd_ready_i));

    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end

    task automatic chk(input logic [63:0] g, e);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // a wait that ran out counts as a mismatch
    task automatic timeout();
        chk(64'h0, 64'h1);
        finish_test();
    endtask
    function automatic int lvl(input int code);
        return (code == 0) ? 0 : (1 << (code - 1));
    endfunction
    // expected flags; upper queues keep only two of them
    function automatic logic [STAT_W-1:0] exp_st(input int q, f, cap,
        ne, nf, input bit uf, ov);
        logic [STAT_W-1:0] s;
        s = '0;
        s[STAT_NEMPTY] = (f <= lvl(ne));
        s[STAT_FULL] = (f == cap);
        if (q < LOWER_QUEUES) begin
            s[STAT_EMPTY] = (f == 0);
            s[STAT_NFULL] = (cap - f <= lvl(nf));
            s[STAT_UNDER] = uf;
            s[STAT_OVER] = ov;
        end
        return s;
    endfunction
    task automatic cfg(input int q, sz, en, ne, nf);
        @(posedge clk_sys_i);
        cfg_we_i <= 1'b1;
        cfg_qid_i <= 6'(q);
        stat_qid_i <= 6'(q);
        cfg_size_i <= 2'(sz);
        cfg_entry_i <= 2'(en);
        cfg_ne_i <= 3'(ne);
        cfg_nf_i <= 3'(nf);
        cfg_int_sel_i <= INT_SEL_FULL;
        @(negedge clk_sys_i);
        chk(cfg_err_o, en == 3);
        @(posedge clk_sys_i);
        cfg_we_i <= 1'b0;
    endtask
    // one word on engine or host port, held until ready
    task automatic acc(input bit eng, rd, input int q, input logic [31:0] d);
        int n;
        @(posedge clk_sys_i);
        eng_valid_i <= eng;
        host_valid_i <= !eng;
        eng_read_i <= rd;
        host_read_i <= rd;
        eng_qid_i <= 6'(q);
        host_qid_i <= 6'(q);
        eng_data_i <= d;
        host_data_i <= d;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_sys_i);
            if ((eng ? eng_ready_o : host_ready_o) === 1'b1) break;
        end
        if (n == 50) timeout();
        eng_valid_i <= 1'b0;
        host_valid_i <= 1'b0;
    endtask
    task automatic pull(input bit eng, uf, input logic [31:0] d);
        int n;
        for (n = 0; n < 50 && sink.got_q.size() == 0; n++)
            @(posedge clk_sys_i);
        if (n == 50) timeout();
        chk(sink.got_q.pop_front(), {eng, uf, d});
    endtask
    task automatic stat(input int q, input bit clr);
        @(posedge clk_sys_i);
        stat_qid_i <= 6'(q);
        stat_rd_i <= clr;
        @(posedge clk_sys_i);
        stat_rd_i <= 1'b0;
        @(negedge clk_sys_i);
        st = stat_o;
    endtask
    task automatic iclr(input int q);
        @(posedge clk_sys_i);
        int_clr_we_i <= 1'b1;
        int_clr_i <= 64'h1 << q;
        @(posedge clk_sys_i);
        int_clr_we_i <= 1'b0;
        @(negedge clk_sys_i);
    endtask
    // fill to full, overflow, drain, underflow, with flag checks
    task automatic run_q(input int q, sz, en, ne, nf);
        int cap, w, i;
        bit e;
        logic [WORD_W-1:0] d;
        cap = (QUEUE_BASE_WORDS << sz) >> en;
        cfg(q, sz, en, ne, nf);
        iclr(q);
        chk(int_stat_o[q], 1'b0);
        for (i = 0; i < cap; i++) begin
            for (w = 0; w < (1 << en); w++) begin
                if (w == (1 << en) - 1) begin
                    stat(q, 1'b0);
                    chk(st, exp_st(q, i, cap, ne, nf, 0, 0));
                end
                d = $urandom;
                sb.push_back(d);
                acc(1'($urandom), 1'b0, q, d);
            end
        end
        iclr(q);
        chk(int_stat_o[q], sticky_en_i);
        acc(1'b0, 1'b0, q, 32'hA5A5A5A5);
        stat(q, 1'b1);
        chk(st, exp_st(q, cap, cap, ne, nf, 0, q < 32));
        for (i = 0; i < (cap << en); i++) begin
            e = 1'($urandom);
            acc(e, 1'b1, q, 32'h0);
            pull(e, 1'b0, sb.pop_front());
        end
        stat(q, 1'b0);
        chk(st, exp_st(q, 0, cap, ne, nf, 0, 0));
        acc(1'b1, 1'b1, q, 32'h0);
        pull(1'b1, 1'b1, 32'h0);
        stat(q, 1'b1);
        chk(st, exp_st(q, 0, cap, ne, nf, q < 32, 0));
        iclr(q);
        chk(int_stat_o[q], 1'b0);
    endtask

    initial begin
        {cfg_we_i, cfg_qid_i, cfg_size_i, cfg_entry_i, cfg_ne_i, cfg_nf_i,
         cfg_int_sel_i, int_clr_we_i, int_clr_i, eng_valid_i, eng_read_i,
         eng_qid_i, eng_data_i, host_valid_i, host_read_i, host_qid_i,
         host_data_i, stat_rd_i, stat_qid_i, stall_en} = '0;
        error_cnt = 0;
        tests_run = 0;
        rst_i = 1'b1;
        sticky_en_i = 1'b1;
        void'($urandom(57));
        repeat (4) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(negedge clk_sys_i);
        chk(int_stat_o, 64'h0);
        chk({stat_o, rd_valid_o, cfg_err_o}, 8'h0);
        cfg(0, 0, 3, 0, 0);
        // every watermark code, both queue halves, all entry sizes
        for (int k = 0; k < 8; k++) begin
            stall_en <= k[0];
            run_q(k * 9, (k >= 5) ? 3 : $urandom % 4, k % 3, k, 7 - k);
        end
        // second reset, edge mode: no spurious interrupt after it
        @(posedge clk_sys_i);
        rst_i <= 1'b1;
        sticky_en_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        repeat (2) @(negedge clk_sys_i);
        chk(int_stat_o, 64'h0);
        run_q(5, 1, 1, 2, 3);
        finish_test();
    end
endmodule // hw_queue_status_watermarks_tb

bind hw_queue_mgr hw_queue_mgr_monitor mon (.*);
